// ===== hw/fepc_pkg.sv
package fepc_pkg;

	// radio state as seen from the transceiver state machine
	typedef enum logic [2:0] {
		FEPC_ST_SLEEP,
		FEPC_ST_IDLE,
		FEPC_ST_RESET,
		FEPC_ST_TRANSMIT_PREPARE_STATE,
		FEPC_ST_TX,
		FEPC_ST_RX
	} fepc_state_e;

	// auxiliary settings, packed in register bit order 7..0
	typedef struct packed {
		logic       lna_bypass_available;
		logic [1:0] gain_map_select;
		logic       analog_supply_external;
		logic       analog_supply_keep_on;
		logic       analog_supply_settled;
		logic [1:0] amp_supply_select;
	} fepc_aux_s;

	// per-transceiver frontend drive
	typedef struct packed {
		logic fe_a;
		logic fe_b;
		logic areg_en;
	} fepc_drive_s;

	// register byte addresses on APB
	localparam logic [7:0] FEPC_OFS_AUX0 = 8'h00;
	localparam logic [7:0] FEPC_OFS_PAD0 = 8'h04;
	localparam logic [7:0] FEPC_OFS_AUX1 = 8'h08;
	localparam logic [7:0] FEPC_OFS_PAD1 = 8'h0c;

	// field positions
	localparam int FEPC_PAD_CFG_LSB = 6;
	localparam int FEPC_PAD_CFG_MSB = 7;

	// reset values
	localparam logic [7:0] FEPC_AUX_RST = 8'h02;
	localparam logic [1:0] FEPC_PAD_RST = 2'h0;

	// encodings
	localparam logic [1:0] FEPC_CFG0     = 2'h0;
	localparam logic [1:0] FEPC_CFG1     = 2'h1;
	localparam logic [1:0] FEPC_CFG2     = 2'h2;
	localparam logic [1:0] FEPC_CFG3     = 2'h3;
	localparam logic [1:0] FEPC_MAP_INT  = 2'h0;
	localparam logic [1:0] FEPC_AMP_2V4  = 2'h2;
	localparam logic [1:0] FEPC_AMP_RSVD = 2'h3;
	localparam logic [6:0] FEPC_GCW_THR  = 7'h11;

endpackage

// ===== hw/fepc_trx.sv
`timescale 1ns/1ns
module fepc_trx (
	// clock and reset
	input  wire logic                CLK,
	input  wire logic                RST_N,
	// register writes
	input  wire logic                wr_aux,
	input  wire logic                wr_pad,
	input  wire logic [7:0]          wdata,
	// radio side
	input  wire fepc_pkg::fepc_state_e state,
	input  wire logic [6:0]          gain_control_word,
	input  wire logic                settled,
	// results
	output fepc_pkg::fepc_aux_s      aux,
	output logic [1:0]               pad_cfg,
	output fepc_pkg::fepc_drive_s    drive
);
	import fepc_pkg::*;

	fepc_aux_s   aux_reg;
	logic [1:0]  pad_reg;
	logic        bypass;
	logic        active;

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			aux_reg <= fepc_aux_s'(FEPC_AUX_RST);
		end else if (wr_aux) begin
			// settled bit is not stored; writes to it are dropped
			aux_reg <= fepc_aux_s'({wdata[7:3], 1'b0, wdata[1:0]});
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			pad_reg <= FEPC_PAD_RST;
		end else if (wr_pad) begin
			pad_reg <= wdata[FEPC_PAD_CFG_MSB:FEPC_PAD_CFG_LSB];
		end
	end

	always_comb begin
		aux                       = aux_reg;
		aux.analog_supply_settled = settled;
	end

	assign pad_cfg = pad_reg;

	////////////////////////////////////////////////////////////////////////////
	// frontend encoding

	// map 0 with bypass available forces bypass; otherwise gain word decides
	assign bypass = aux_reg.lna_bypass_available &&
		(aux_reg.gain_map_select == FEPC_MAP_INT || gain_control_word <= FEPC_GCW_THR);

	assign active = (state == FEPC_ST_TRANSMIT_PREPARE_STATE) || (state == FEPC_ST_TX) || (state == FEPC_ST_RX);

	always_comb begin
		drive = '0;
		case (state)
			FEPC_ST_TX: begin
				case (pad_reg)
					FEPC_CFG1: {drive.fe_a, drive.fe_b} = 2'h2;
					FEPC_CFG2: {drive.fe_a, drive.fe_b} = 2'h3;
					FEPC_CFG3: {drive.fe_a, drive.fe_b} = 2'h3;
					default:   {drive.fe_a, drive.fe_b} = 2'h0;
				endcase
			end
			FEPC_ST_RX: begin
				case (pad_reg)
					FEPC_CFG1: {drive.fe_a, drive.fe_b} = bypass ? 2'h3 : 2'h1;
					FEPC_CFG2: {drive.fe_a, drive.fe_b} = bypass ? 2'h2 : 2'h1;
					FEPC_CFG3: {drive.fe_a, drive.fe_b} = bypass ? 2'h0 : 2'h1;
					default:   {drive.fe_a, drive.fe_b} = 2'h0;
				endcase
			end
			default: {drive.fe_a, drive.fe_b} = 2'h0;
		endcase
		// external supply wins over everything; sleep always off
		drive.areg_en = !aux_reg.analog_supply_external &&
			(active || (aux_reg.analog_supply_keep_on && state != FEPC_ST_SLEEP));
	end

endmodule // fepc_trx

// ===== hw/fepc_top.sv
`timescale 1ns/1ns
module fepc_top (
	// clock and reset
	input  wire logic                  CLK,
	input  wire logic                  RST_N,
	// apb slave
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [7:0]            PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic                       PREADY,
	output logic [31:0]                PRDATA,
	output logic                       PSLVERR,
	// radio state machines and gain control
	input  wire fepc_pkg::fepc_state_e STATE_SUBGHZ,
	input  wire fepc_pkg::fepc_state_e STATE_2G4,
	input  wire logic [6:0]            GCW_SUBGHZ,
	input  wire logic [6:0]            GCW_2G4,
	// analog supply settled pins
	input  wire logic                  SETTLED_SUBGHZ,
	input  wire logic                  SETTLED_2G4,
	// frontend control pins
	output logic                       FRONTEND_CTRL_A_SUBGHZ,
	output logic                       FRONTEND_CTRL_B_SUBGHZ,
	output logic                       FRONTEND_CTRL_A_2G4,
	output logic                       FRONTEND_CTRL_B_2G4,
	// regulators, amplifier supply and gain map
	output logic                       ANALOG_REGULATOR_SUBGHZ,
	output logic                       ANALOG_REGULATOR_2G4,
	output logic                       DIGITAL_REGULATOR,
	output logic [1:0]                 AMP_SUPPLY_SUBGHZ,
	output logic [1:0]                 AMP_SUPPLY_2G4,
	output logic [1:0]                 GAIN_MAP_SUBGHZ,
	output logic [1:0]                 GAIN_MAP_2G4
);
	import fepc_pkg::*;

	logic                 access;
	logic                 take;
	logic                 mapped;
	logic [7:0]           rdata;
	logic [1:0]           settled_meta_reg;
	logic [1:0]           settled_sync_reg;
	logic [1:0]           wr_aux;
	logic [1:0]           wr_pad;
	fepc_aux_s            aux [2];
	logic [1:0]           pad [2];
	fepc_drive_s          drive [2];
	fepc_state_e          st [2];
	logic [6:0]           gain_control_word [2];

	// reserved amp code 3 falls back to the highest defined level
	function automatic logic [1:0] amp_level(input logic [1:0] code);
		amp_level = (code == FEPC_AMP_RSVD) ? FEPC_AMP_2V4 : code;
	endfunction

	// reserved gain map 3 behaves as the 12 dB map
	function automatic logic [1:0] map_level(input logic [1:0] code);
		map_level = (code == 2'h3) ? 2'h2 : code;
	endfunction

	assign st[0]  = STATE_SUBGHZ;
	assign st[1]  = STATE_2G4;
	assign gain_control_word[0] = GCW_SUBGHZ;
	assign gain_control_word[1] = GCW_2G4;

	////////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, answer in the second access cycle

	assign access = PSEL && PENABLE;
	assign take   = access && !PREADY;

	always_comb begin
		mapped = 1'b1;
		rdata  = 8'h00;
		wr_aux = 2'h0;
		wr_pad = 2'h0;
		case (PADDR)
			FEPC_OFS_AUX0: begin
				rdata     = aux[0];
				wr_aux[0] = take && PWRITE;
			end
			FEPC_OFS_PAD0: begin
				rdata     = {pad[0], 6'h00};
				wr_pad[0] = take && PWRITE;
			end
			FEPC_OFS_AUX1: begin
				rdata     = aux[1];
				wr_aux[1] = take && PWRITE;
			end
			FEPC_OFS_PAD1: begin
				rdata     = {pad[1], 6'h00};
				wr_pad[1] = take && PWRITE;
			end
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PREADY <= 1'b0;
		end else begin
			PREADY <= take;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else if (take) begin
			PRDATA  <= (mapped && !PWRITE) ? {24'h000000, rdata} : 32'h0000_0000;
			PSLVERR <= !mapped;
		end else begin
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// settled pins come from the analog domain

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			settled_meta_reg <= 2'h0;
			settled_sync_reg <= 2'h0;
		end else begin
			settled_meta_reg <= {SETTLED_2G4, SETTLED_SUBGHZ};
			settled_sync_reg <= settled_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transceivers

	for (genvar i = 0; i < 2; i++) begin : g_trx
		fepc_trx u_trx (
			.CLK     (CLK),
			.RST_N   (RST_N),
			.wr_aux  (wr_aux[i]),
			.wr_pad  (wr_pad[i]),
			.wdata   (PWDATA[7:0]),
			.state   (st[i]),
			.gain_control_word     (gain_control_word[i]),
			.settled (settled_sync_reg[i]),
			.aux     (aux[i]),
			.pad_cfg (pad[i]),
			.drive   (drive[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// registered outputs; one cycle behind the radio state or, for amp supply and gain map, the aux registers

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			FRONTEND_CTRL_A_SUBGHZ <= 1'b0;
			FRONTEND_CTRL_B_SUBGHZ <= 1'b0;
			FRONTEND_CTRL_A_2G4    <= 1'b0;
			FRONTEND_CTRL_B_2G4    <= 1'b0;
		end else begin
			FRONTEND_CTRL_A_SUBGHZ <= drive[0].fe_a;
			FRONTEND_CTRL_B_SUBGHZ <= drive[0].fe_b;
			FRONTEND_CTRL_A_2G4    <= drive[1].fe_a;
			FRONTEND_CTRL_B_2G4    <= drive[1].fe_b;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ANALOG_REGULATOR_SUBGHZ <= 1'b0;
			ANALOG_REGULATOR_2G4    <= 1'b0;
		end else begin
			ANALOG_REGULATOR_SUBGHZ <= drive[0].areg_en;
			ANALOG_REGULATOR_2G4    <= drive[1].areg_en;
		end
	end

	// no register term reaches this flop: it depends on the two states only
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DIGITAL_REGULATOR <= 1'b1;
		end else begin
			DIGITAL_REGULATOR <= !(st[0] == FEPC_ST_SLEEP && st[1] == FEPC_ST_SLEEP);
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			AMP_SUPPLY_SUBGHZ <= FEPC_AMP_2V4;
			AMP_SUPPLY_2G4    <= FEPC_AMP_2V4;
			GAIN_MAP_SUBGHZ   <= FEPC_MAP_INT;
			GAIN_MAP_2G4      <= FEPC_MAP_INT;
		end else begin
			AMP_SUPPLY_SUBGHZ <= amp_level(aux[0].amp_supply_select);
			AMP_SUPPLY_2G4    <= amp_level(aux[1].amp_supply_select);
			GAIN_MAP_SUBGHZ   <= map_level(aux[0].gain_map_select);
			GAIN_MAP_2G4      <= map_level(aux[1].gain_map_select);
		end
	end

endmodule // fepc_top

// ===== dv/fepc_top_monitor.sv
`timescale 1ns/1ns
module fepc_top_monitor
	import fepc_pkg::*;
(
	// clock and reset
	input wire logic              CLK,
	input wire logic              RST_N,
	// apb
	input wire logic              PSEL,
	input wire logic              PENABLE,
	input wire logic [7:0]        PADDR,
	input wire logic              PREADY,
	input wire logic [31:0]       PRDATA,
	input wire logic              PSLVERR,
	// radio and pins
	input wire fepc_state_e       STATE_SUBGHZ,
	input wire fepc_state_e       STATE_2G4,
	input wire logic              FRONTEND_CTRL_A_SUBGHZ,
	input wire logic              FRONTEND_CTRL_B_SUBGHZ,
	input wire logic              ANALOG_REGULATOR_SUBGHZ,
	input wire logic              DIGITAL_REGULATOR,
	input wire logic [1:0]        AMP_SUPPLY_SUBGHZ,
	input wire logic [1:0]        GAIN_MAP_SUBGHZ
);
	logic tk;
	logic map_ok;
	logic both_sleep;
	logic active;
	assign tk = PSEL && PENABLE && !PREADY;
	assign map_ok = PADDR inside {FEPC_OFS_AUX0, FEPC_OFS_PAD0, FEPC_OFS_AUX1, FEPC_OFS_PAD1};
	assign both_sleep = STATE_SUBGHZ == FEPC_ST_SLEEP && STATE_2G4 == FEPC_ST_SLEEP;
	assign active = STATE_SUBGHZ inside {FEPC_ST_TX, FEPC_ST_RX};
	////////////////////////////////
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	// one wait state, one-cycle answer
	ans_delay_a: assert property (tk |=> PREADY ##1 !PREADY)
		else $error("apb answer late or long");
	bad_addr_a: assert property (tk && !map_ok |=> PSLVERR && PRDATA == 32'h0)
		else $error("unmapped access not refused");
	good_addr_a: assert property (tk && map_ok |=> !PSLVERR)
		else $error("mapped access refused");
	dig_off_a: assert property (both_sleep |=> !DIGITAL_REGULATOR)
		else $error("digital regulator on in deep sleep");
	dig_on_a: assert property (!both_sleep |=> DIGITAL_REGULATOR)
		else $error("digital regulator off while awake");
	fe_off_a: assert property (!active |=> !FRONTEND_CTRL_A_SUBGHZ && !FRONTEND_CTRL_B_SUBGHZ)
		else $error("frontend pins not off");
	fe_tx_a: assert property (STATE_SUBGHZ == FEPC_ST_TX |=> FRONTEND_CTRL_A_SUBGHZ || !FRONTEND_CTRL_B_SUBGHZ)
		else $error("bad transmit pin code");
	areg_sleep_a: assert property (STATE_SUBGHZ == FEPC_ST_SLEEP |=> !ANALOG_REGULATOR_SUBGHZ)
		else $error("analog regulator on in sleep");
	amp_rsvd_a: assert property (AMP_SUPPLY_SUBGHZ != 2'h3 && GAIN_MAP_SUBGHZ != 2'h3)
		else $error("reserved code reached a pin");
	cover property (tk && !map_ok);
	cover property (both_sleep ##1 !DIGITAL_REGULATOR);
	cover property (FRONTEND_CTRL_A_SUBGHZ && FRONTEND_CTRL_B_SUBGHZ);
endmodule // fepc_top_monitor

bind fepc_top fepc_top_monitor mon (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
	.PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
	.STATE_SUBGHZ(STATE_SUBGHZ), .STATE_2G4(STATE_2G4),
	.FRONTEND_CTRL_A_SUBGHZ(FRONTEND_CTRL_A_SUBGHZ), .FRONTEND_CTRL_B_SUBGHZ(FRONTEND_CTRL_B_SUBGHZ),
	.ANALOG_REGULATOR_SUBGHZ(ANALOG_REGULATOR_SUBGHZ), .DIGITAL_REGULATOR(DIGITAL_REGULATOR),
	.AMP_SUPPLY_SUBGHZ(AMP_SUPPLY_SUBGHZ), .GAIN_MAP_SUBGHZ(GAIN_MAP_SUBGHZ));

// ===== dv/fepc_fe_model.sv
`timescale 1ns/1ns
module fepc_fe_model (
	// clock and radio state
	input wire logic              CLK,
	input wire fepc_pkg::fepc_state_e st,
	input wire logic [1:0]        cfg,
	// frontend pins
	input wire logic              fe_a,
	input wire logic              fe_b,
	// host enable, decoded mode: 0 off 1 tx 2 rx 3 bypass
	output logic                  mcu_en,
	output logic [1:0]            mode
);
	import fepc_pkg::*;
	// host pin follows the radio, same lag as the device pins
	always_ff @(posedge CLK) begin
		mcu_en <= st inside {FEPC_ST_TX, FEPC_ST_RX};
	end
	always_comb begin
		mode = 2'h0;
		case (cfg)
			2'h1: mode = fe_a ? (fe_b ? 2'h3 : 2'h1) : (fe_b ? 2'h2 : 2'h0);
			2'h2: mode = fe_a ? (fe_b ? 2'h1 : 2'h3) : (fe_b ? 2'h2 : 2'h0);
			// module cannot switch off by pins alone here
			2'h3: if (mcu_en) mode = fe_a ? 2'h1 : (fe_b ? 2'h2 : 2'h3);
			default: ;
		endcase
	end
endmodule // fepc_fe_model

// ===== dv/fepc_top_tb.sv
`timescale 1ns/1ns
module fepc_top_tb;
	import fepc_pkg::*;
	localparam logic [31:0] FE_TBL = 32'h1c9cd800;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, settled = 0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, fa_s, fb_s, fa_2, fb_2, ar_s, ar_2, dreg, mcu_en;
	fepc_state_e st_s = FEPC_ST_IDLE, st_2 = FEPC_ST_IDLE;
	logic [6:0] gain_control_word = 7'h0;
	logic [1:0] cfg = 2'h0, mode, amp_s, amp_2, gm_s, gm_2;
	int error_cnt = 0, num_checks = 0;
	always #20 clk = ~clk;
	fepc_top dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
		.STATE_SUBGHZ(st_s), .STATE_2G4(st_2), .GCW_SUBGHZ(gain_control_word), .GCW_2G4(gain_control_word),
		.SETTLED_SUBGHZ(settled), .SETTLED_2G4(settled),
		.FRONTEND_CTRL_A_SUBGHZ(fa_s), .FRONTEND_CTRL_B_SUBGHZ(fb_s),
		.FRONTEND_CTRL_A_2G4(fa_2), .FRONTEND_CTRL_B_2G4(fb_2),
		.ANALOG_REGULATOR_SUBGHZ(ar_s), .ANALOG_REGULATOR_2G4(ar_2), .DIGITAL_REGULATOR(dreg),
		.AMP_SUPPLY_SUBGHZ(amp_s), .AMP_SUPPLY_2G4(amp_2), .GAIN_MAP_SUBGHZ(gm_s),
		.GAIN_MAP_2G4(gm_2));
	fepc_fe_model fem (.CLK(clk), .st(st_s), .cfg(cfg), .fe_a(fa_s), .fe_b(fb_s),
		.mcu_en(mcu_en), .mode(mode));
	////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, s, x);
		end
	endtask
	// bounded wait: a dead slave must not hang the run
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// look between edges: the answer is launched by a rising edge
		do begin
			@(negedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			error_cnt++;
			end_of_test;
		end
		r = prdata;
		e = pslverr;
		// hold the request through the edge that samples pready high
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr2(input logic [7:0] o, input logic [7:0] d);
		apb(1'b1, o, {24'h0, d});
		apb(1'b1, o + 8'h08, {24'h0, d});
	endtask
	task automatic radio(input fepc_state_e a, input fepc_state_e b, input logic [6:0] g);
		@(posedge clk);
		st_s <= a;
		st_2 <= b;
		gain_control_word <= g;
		repeat (2) @(negedge clk);
	endtask
	////////////////////////////////
	task automatic t_regs;
		chk(32'({dreg, amp_s, gm_s, fa_s}), 32'h30);
		apb(1'b0, FEPC_OFS_AUX0, 32'h0);
		chk(r, 32'h02);
		wr2(8'h04, 8'hff);
		apb(1'b0, FEPC_OFS_PAD1, 32'h0);
		chk(r, 32'hc0);
		wr2(8'h00, 8'hff);
		apb(1'b0, FEPC_OFS_AUX1, 32'h0);
		chk(r, 32'hfb);
		chk(32'({amp_s, gm_2}), 32'ha);
		settled <= 1'b1;
		repeat (3) @(posedge clk);
		apb(1'b0, FEPC_OFS_AUX0, 32'h0);
		chk(r, 32'hff);
		for (int i = 0; i < 3; i++) begin
			wr2(8'h00, 8'(i * 33));
			@(negedge clk);
			chk(32'({amp_s, amp_2, gm_s}), 32'(i * 21));
		end
		apb(1'b1, 8'h10, 32'hff);
		chk(32'(e), 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(e), 32'h1);
		chk(r, 32'h0);
	endtask
	task automatic t_pins;
		logic [1:0] x;
		fepc_state_e s;
		wr2(8'h00, 8'ha2);
		for (int c = 0; c < 4; c++) begin
			wr2(8'h04, 8'(c << 6));
			cfg <= 2'(c);
			for (int k = 0; k < 4; k++) begin
				s = k == 0 ? FEPC_ST_TRANSMIT_PREPARE_STATE : (k == 1 ? FEPC_ST_TX : FEPC_ST_RX);
				// gain word 18 keeps the lna, 17 bypasses it
				radio(s, s, k == 3 ? 7'h11 : 7'h12);
				x = FE_TBL[(c * 4 + k) * 2 +: 2];
				chk(32'({fa_s, fb_s, fa_2, fb_2}), 32'({x, x}));
				chk(32'(mode), c == 0 ? 32'h0 : 32'(k));
			end
		end
		wr2(8'h04, 8'h40);
		wr2(8'h00, 8'h82);
		radio(FEPC_ST_RX, FEPC_ST_RX, 7'h7f);
		chk(32'({fa_s, fb_s}), 32'h3);
	endtask
	task automatic t_power;
		logic [7:0] a;
		logic on;
		for (int j = 0; j < 3; j++) begin
			a = j == 0 ? 8'h1a : (j == 1 ? 8'h0a : 8'h02);
			wr2(8'h00, a);
			for (int s = 0; s < 6; s++) begin
				radio(fepc_state_e'(s), FEPC_ST_SLEEP, 7'h0);
				on = !a[4] && (s > 2 || (a[3] && s != 0));
				chk(32'({ar_s, ar_2, dreg}), 32'({on, 1'b0, s != 0}));
				if (s < 3) chk(32'({fa_s, fb_s}), 32'h0);
			end
		end
		radio(FEPC_ST_SLEEP, FEPC_ST_TX, 7'h0);
		chk(32'({ar_s, ar_2, dreg}), 32'h3);
	endtask
	// mid-run reset: registers back to defaults, settled pin still high
	task automatic t_reset;
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'({ar_2, dreg}), 32'h1);
		rst_n <= 1'b1;
		apb(1'b0, FEPC_OFS_AUX1, 32'h0);
		chk(r, 32'h06);
		apb(1'b0, FEPC_OFS_PAD0, 32'h0);
		chk(r, 32'h00);
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_pins;
		t_power;
		t_reset;
		end_of_test;
	end
endmodule // fepc_top_tb
